/* File: design/ara_accum.sv */
/*
 * ADC result accumulator: running sum of conversion results, sample counter, overflow flag,
 * self-clearing clear command, shifted filter result, interrupt status, all behind an APB slave.
 * Assumes conv_result comes from the converter core on pclk and is valid whenever a trigger
 * occurs; ext_trig comes from a pin and is synchronised here.
 */
// Notes on behaviour
// - Each trigger, software start or external edge, adds the conversion result in every mode except basic mode 000.
// - Software reads the accumulator as a 16-bit value via high and low bytes.
// - A sum beyond 262143 sets the sticky overflow flag in the status register.
// - Every sample added into the accumulator increments the sample count by one.
// - Setting the clear bit clears accumulator, overflow flag and sample count.
// - Hardware drops the clear bit when clearing completes, so software can poll it.
// - The clear operation takes five clock cycles before it completes.
// - The accumulator is right-shifted by the 3-bit shift field into the filter result.
// - Basic mode 000 adds nothing into the accumulator.
// - Accumulate mode 001 copies the shifted accumulator into the filter result each sample.
`default_nettype none
`include "ara_consts.svh"

module ara_accum
    import ara_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] conv_result,
    input wire logic ext_trig,
    output logic irq
);

    // ****************************************************************
    // State registers
    // ****************************************************************
    ara_state_s s_r;
    ara_state_s s_nxt;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // One process computes the whole next state so the bus, the sequencer and the datapath
    // all see the same current values and no field has two drivers.
    always_comb begin
        logic setup;
        logic wr;
        logic trig;
        logic adding;
        logic clr_done;
        logic [`ARA_ACC_W:0] sum;
        logic [`ARA_ACC_W-1:0] base_acc;
        logic [7:0] base_cnt;
        logic [7:0] new_cnt;
        logic [3:0] ev;
        logic [31:0] rd;
        logic hit;
        setup = 1'b0;
        wr = 1'b0;
        trig = 1'b0;
        adding = 1'b0;
        clr_done = 1'b0;
        sum = '0;
        base_acc = '0;
        base_cnt = '0;
        new_cnt = '0;
        ev = '0;
        rd = '0;
        hit = 1'b0;
        s_nxt = s_r;

        // Pin synchroniser; only the second stage and its delayed copy feed the edge detector.
        s_nxt.trig_s1 = ext_trig;
        s_nxt.trig_s2 = s_r.trig_s1;
        s_nxt.trig_d = s_r.trig_s2;

        // A trigger is a start strobe or a rising edge of the external pin.
        trig = s_r.start_bit | (s_r.trig_s2 & ~s_r.trig_d);
        s_nxt.start_bit = 1'b0;

        // Clear sequencer: counts down, then wipes the sum, the count and the overflow flag.
        unique case (s_r.st)
            ARA_ST_IDLE: begin
                clr_done = 1'b0;
            end
            ARA_ST_CLEARING: begin
                if (s_r.clr_cnt == 3'h0) begin
                    clr_done = 1'b1;
                    s_nxt.st = ARA_ST_IDLE;
                    s_nxt.clr_bit = 1'b0;
                end else begin
                    s_nxt.clr_cnt = s_r.clr_cnt - 3'h1;
                end
            end
        endcase

        // A sample that lands on the completing cycle is added after the wipe, not lost.
        base_acc = clr_done ? '0 : s_r.acc;
        base_cnt = clr_done ? 8'h00 : s_r.cnt;
        if (clr_done) begin
            s_nxt.ovf = 1'b0;
            s_nxt.acc = '0;
            s_nxt.cnt = 8'h00;
            ev[`ARA_IRQ_CLR_DONE] = 1'b1;
        end

        // Basic mode skips accumulation; every other mode adds into the sum.
        adding = trig && (s_r.mode != ARA_MODE_BASIC);
        sum = {1'b0, base_acc} + {3'b000, conv_result};
        new_cnt = base_cnt + 8'h01;
        if (adding) begin
            s_nxt.acc = sum[`ARA_ACC_W-1:0];
            s_nxt.cnt = new_cnt;
            s_nxt.filt = 16'(sum[`ARA_ACC_W-1:0] >> s_r.shift);
            ev[`ARA_IRQ_SAMPLE] = 1'b1;
            hit = (new_cnt == s_r.repeat_target);
            ev[`ARA_IRQ_RPT_HIT] = hit;
            if (sum > `ARA_ACC_MAX) begin
                // Set wins over the clear of the same cycle.
                s_nxt.ovf = 1'b1;
                ev[`ARA_IRQ_OVF] = 1'b1;
            end
        end

        // APB: answer is prepared in the setup cycle, so the access phase always ends at once.
        setup = psel & ~penable;
        wr = psel & penable & s_r.pready & pwrite;
        s_nxt.pready = setup;
        s_nxt.pslverr = 1'b0;
        unique case (paddr)
            `ARA_OFF_ACC_LO: rd = {24'h000000, s_r.acc[7:0]};
            `ARA_OFF_ACC_HI: rd = {24'h000000, s_r.acc[15:8]};
            `ARA_OFF_STATUS: rd = {30'h0, (s_r.st == ARA_ST_CLEARING), s_r.ovf};
            `ARA_OFF_CTRL2: rd = {24'h000000, s_r.start_bit, s_r.mode, s_r.clr_bit, s_r.shift};
            `ARA_OFF_RPT: rd = {24'h000000, s_r.repeat_target};
            `ARA_OFF_CNT: rd = {24'h000000, s_r.cnt};
            `ARA_OFF_FLT: rd = {16'h0000, s_r.filt};
            `ARA_OFF_IRQ_STAT: rd = {28'h0000000, s_r.irq_stat};
            `ARA_OFF_IRQ_EN: rd = {28'h0000000, s_r.irq_en};
            `ARA_OFF_IRQ_CLR: rd = 32'h00000000;
            default: begin
                rd = 32'h00000000;
                s_nxt.pslverr = setup;
            end
        endcase
        if (setup) begin
            s_nxt.prdata = pwrite ? 32'h00000000 : rd;
        end

        // Register writes take effect at the edge that completes the access phase.
        s_nxt.irq_stat = s_r.irq_stat;
        if (wr) begin
            unique case (paddr)
                `ARA_OFF_CTRL2: begin
                    s_nxt.shift = pwdata[`ARA_CTRL_SHIFT_LSB +: 3];
                    s_nxt.mode = ara_mode_e'(pwdata[`ARA_CTRL_MODE_LSB +: 3]);
                    s_nxt.start_bit = pwdata[`ARA_CTRL_START_BIT];
                    // A clear already running is not restarted by a second write.
                    if (pwdata[`ARA_CTRL_CLR_BIT] && (s_r.st == ARA_ST_IDLE)) begin
                        s_nxt.clr_bit = 1'b1;
                        s_nxt.st = ARA_ST_CLEARING;
                        s_nxt.clr_cnt = `ARA_CLR_CYCLES - 3'h1;
                    end
                end
                `ARA_OFF_RPT: s_nxt.repeat_target = pwdata[7:0];
                `ARA_OFF_IRQ_EN: s_nxt.irq_en = pwdata[3:0];
                `ARA_OFF_IRQ_CLR: s_nxt.irq_stat = s_r.irq_stat & ~pwdata[3:0];
                default: begin
                    s_nxt.repeat_target = s_nxt.repeat_target;
                end
            endcase
        end

        // Events are ORed in after the clear, so a set in the same cycle survives.
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
        s_nxt.irq = |(s_r.irq_stat & s_r.irq_en);
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset puts every field to a constant; the pin synchroniser starts low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.acc <= '0;
            s_r.filt <= 16'h0000;
            s_r.cnt <= 8'h00;
            s_r.repeat_target <= `ARA_RST_RPT;
            s_r.shift <= `ARA_RST_SHIFT;
            s_r.mode <= ARA_MODE_BASIC;
            s_r.clr_bit <= 1'b0;
            s_r.start_bit <= 1'b0;
            s_r.ovf <= 1'b0;
            s_r.st <= ARA_ST_IDLE;
            s_r.clr_cnt <= 3'h0;
            s_r.trig_s1 <= 1'b0;
            s_r.trig_s2 <= 1'b0;
            s_r.trig_d <= 1'b0;
            s_r.irq_stat <= 4'h0;
            s_r.irq_en <= 4'h0;
            s_r.irq <= 1'b0;
            s_r.prdata <= 32'h00000000;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs, each straight from a flip-flop
    // ****************************************************************
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;

endmodule

`default_nettype wire

/* File: include/ara_consts.svh */
/*
 * Register offsets, field positions, reset values and counts for the ADC result accumulator.
 * Assumes it is included by bare name before any code that uses these macros.
 */
`ifndef ARA_CONSTS_SVH
`define ARA_CONSTS_SVH

// ****************************************************************
// Register byte offsets on the APB slave
// ****************************************************************
`define ARA_OFF_ACC_LO 12'h000
`define ARA_OFF_ACC_HI 12'h004
`define ARA_OFF_STATUS 12'h008
`define ARA_OFF_CTRL2 12'h00c
`define ARA_OFF_RPT 12'h010
`define ARA_OFF_CNT 12'h014
`define ARA_OFF_FLT 12'h018
`define ARA_OFF_IRQ_STAT 12'h01c
`define ARA_OFF_IRQ_EN 12'h020
`define ARA_OFF_IRQ_CLR 12'h024

// ****************************************************************
// Field positions of the control and status registers
// ****************************************************************
`define ARA_CTRL_SHIFT_LSB 0
`define ARA_CTRL_CLR_BIT 3
`define ARA_CTRL_MODE_LSB 4
`define ARA_CTRL_START_BIT 7
`define ARA_STAT_OVF_BIT 0
`define ARA_STAT_BUSY_BIT 1

// Interrupt status bits.
`define ARA_IRQ_SAMPLE 0
`define ARA_IRQ_OVF 1
`define ARA_IRQ_CLR_DONE 2
`define ARA_IRQ_RPT_HIT 3

// ****************************************************************
// Widths, limits, reset values and counts
// ****************************************************************
`define ARA_ACC_W 18
`define ARA_ACC_MAX 19'h3ffff
`define ARA_CLR_CYCLES 3'h5
`define ARA_RST_RPT 8'h00
`define ARA_RST_MODE 3'h0
`define ARA_RST_SHIFT 3'h0

`endif

/* File: include/ara_pkg.sv */
/*
 * Types shared by the ADC result accumulator.
 * Assumes ara_consts.svh is on the include path.
 */
`default_nettype none
`include "ara_consts.svh"

package ara_pkg;

    // Computation modes held in the mode field.
    typedef enum logic [2:0] {
        ARA_MODE_BASIC,
        ARA_MODE_ACCUM,
        ARA_MODE_AVG,
        ARA_MODE_OTHER3,
        ARA_MODE_OTHER4,
        ARA_MODE_OTHER5,
        ARA_MODE_OTHER6,
        ARA_MODE_OTHER7
    } ara_mode_e;

    // Sequencer of the accumulator clear command.
    typedef enum logic [0:0] {
        ARA_ST_IDLE,
        ARA_ST_CLEARING
    } ara_clr_e;

    // All state of the accumulator block.
    typedef struct packed {
        logic [`ARA_ACC_W-1:0] acc;
        logic [15:0] filt;
        logic [7:0] cnt;
        logic [7:0] repeat_target;
        logic [2:0] shift;
        ara_mode_e mode;
        logic clr_bit;
        logic start_bit;
        logic ovf;
        ara_clr_e st;
        logic [2:0] clr_cnt;
        logic trig_s1;
        logic trig_s2;
        logic trig_d;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ara_state_s;

endpackage

`default_nettype wire

/* File: tb/ara_accum_sva.sv */
/* Checker of the APB answers and read-back widths of ara_accum.
   Assumes it is bound to ara_accum and sees only that module's ports. */
`default_nettype none
`include "ara_consts.svh"
module ara_accum_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] conv_result,
    input wire logic ext_trig,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // All checks share the bus clock and drop out while reset is low.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_w = pready && !pwrite;
    // Bus answers, then the width of the accumulator, count, filter and status values read back.
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("pready is not a one-cycle answer to setup.");
    property p_only; pready |-> psel && penable; endproperty
    a_only: assert property (p_only) else $error("pready outside an access phase.");
    property p_err; psel && !penable && paddr > `ARA_OFF_IRQ_CLR |=> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("Unmapped address not refused.");
    property p_wr; pready && pwrite |-> prdata == 32'h0; endproperty
    a_wr: assert property (p_wr) else $error("Read data driven during a write.");
    property p_errq; pslverr |-> pready; endproperty
    a_errq: assert property (p_errq) else $error("Error response outside an access answer.");
    property p_acc; rd_w && (paddr == `ARA_OFF_ACC_LO || paddr == `ARA_OFF_ACC_HI) |-> prdata[31:8] == 24'h0; endproperty
    a_acc: assert property (p_acc) else $error("Accumulator byte wider than eight bits.");
    property p_cnt; rd_w && paddr == `ARA_OFF_CNT |-> prdata[31:8] == 24'h0; endproperty
    a_cnt: assert property (p_cnt) else $error("Sample count wider than eight bits.");
    property p_flt; rd_w && paddr == `ARA_OFF_FLT |-> prdata[31:16] == 16'h0; endproperty
    a_flt: assert property (p_flt) else $error("Filter result wider than sixteen bits.");
    property p_stat; rd_w && paddr == `ARA_OFF_STATUS |-> prdata[31:2] == 30'h0; endproperty
    a_stat: assert property (p_stat) else $error("Status has bits beyond flag and busy.");
endmodule
bind ara_accum ara_accum_sva ara_accum_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_result(conv_result), .ext_trig(ext_trig), .irq(irq));
`default_nettype wire

/* File: tb/ara_conv_model.sv */
/* Converter core model: hands results to the accumulator and pulses the trigger pin.
   Assumes the bench raises load or fire for one cycle per conversion. */
`default_nettype none
module ara_conv_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic fire,
    input wire logic [15:0] val,
    output logic [15:0] conv_result,
    output logic ext_trig
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] len_r;
    // The core holds its last result; the pin pulse lasts four cycles to survive the synchroniser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_result <= 16'h0;
            len_r <= 3'h0;
        end else begin
            if (load || fire) begin
                conv_result <= val;
            end
            len_r <= fire ? 3'h4 : len_r - {2'h0, len_r != 3'h0};
        end
    end
    assign ext_trig = len_r != 3'h0;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
/* Self-checking bench of ara_accum driven over APB with a converter core model.
   Assumes the design, package, checker and model are compiled before it. */
`default_nettype none
`include "ara_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] conv_result;
    logic ext_trig;
    logic irq;
    logic load = 1'b0;
    logic fire = 1'b0;
    logic [15:0] val = 16'h0;
    logic [7:0] ctl = 8'h0;
    logic [31:0] r;
    logic e;
    int fails = 0;
    int comparisons = 0;
    ara_accum ara_accum_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_result(conv_result), .ext_trig(ext_trig), .irq(irq));
    ara_conv_model ara_conv_model_inst (.pclk(pclk), .presetn(presetn), .load(load), .fire(fire), .val(val),
        .conv_result(conv_result), .ext_trig(ext_trig));
    // A 25 ns bus clock.
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    task automatic final_report();
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One transfer, then one idle edge so that the next call never re-drives psel in the same step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", 32'h0, 32'h1);
            final_report();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, r, exp);
    endtask
    // Software start: the core loads its result first, then the start bit fires.
    task automatic sw(input logic [15:0] v);
        val <= v;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        wr(`ARA_OFF_CTRL2, {24'h0, ctl | 8'h80});
        cyc(3);
    endtask
    task automatic hw(input logic [15:0] v);
        val <= v;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        cyc(8);
    endtask
    initial begin
        cyc(4);
        presetn <= 1'b1;
        rd("ctrl2", `ARA_OFF_CTRL2, 32'h0);
        rd("repeat_target", `ARA_OFF_RPT, 32'h0);
        rd("status", `ARA_OFF_STATUS, 32'h0);
        sw(16'h1234);
        rd("acc_lo", `ARA_OFF_ACC_LO, 32'h0);
        rd("count", `ARA_OFF_CNT, 32'h0);
        ctl = 8'h10;
        wr(`ARA_OFF_CTRL2, {24'h0, ctl});
        sw(16'h1234);
        rd("acc_lo", `ARA_OFF_ACC_LO, 32'h34);
        rd("acc_hi", `ARA_OFF_ACC_HI, 32'h12);
        rd("count", `ARA_OFF_CNT, 32'h1);
        rd("filter", `ARA_OFF_FLT, 32'h1234);
        hw(16'h0100);
        rd("acc_hi", `ARA_OFF_ACC_HI, 32'h13);
        rd("count", `ARA_OFF_CNT, 32'h2);
        ctl = 8'h14;
        wr(`ARA_OFF_CTRL2, {24'h0, ctl});
        sw(16'h0000);
        rd("filter", `ARA_OFF_FLT, 32'h133);
        repeat (3) sw(16'hffff);
        rd("status", `ARA_OFF_STATUS, 32'h0);
        sw(16'hffff);
        rd("status", `ARA_OFF_STATUS, 32'h1);
        rd("acc_lo", `ARA_OFF_ACC_LO, 32'h30);
        sw(16'h0001);
        rd("status", `ARA_OFF_STATUS, 32'h1);
        rd("count", `ARA_OFF_CNT, 32'h8);
        wr(`ARA_OFF_IRQ_EN, 32'h2);
        cyc(2);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(`ARA_OFF_IRQ_EN, 32'h0);
        cyc(2);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`ARA_OFF_IRQ_EN, 32'h2);
        wr(`ARA_OFF_IRQ_CLR, 32'h2);
        cyc(2);
        chk("irq", {31'h0, irq}, 32'h0);
        rd("irq_status", `ARA_OFF_IRQ_STAT, 32'h1);
        wr(`ARA_OFF_RPT, 32'h8);
        wr(`ARA_OFF_CTRL2, {24'h0, ctl | 8'h08});
        rd("ctrl2", `ARA_OFF_CTRL2, {24'h0, ctl | 8'h08});
        cyc(1);
        rd("ctrl2", `ARA_OFF_CTRL2, {24'h0, ctl});
        rd("acc_hi", `ARA_OFF_ACC_HI, 32'h0);
        rd("count", `ARA_OFF_CNT, 32'h0);
        rd("status", `ARA_OFF_STATUS, 32'h0);
        rd("irq_status", `ARA_OFF_IRQ_STAT, 32'h5);
        wr(`ARA_OFF_IRQ_CLR, 32'hf);
        wr(`ARA_OFF_RPT, 32'h2);
        sw(16'h0005);
        sw(16'h0005);
        rd("acc_lo", `ARA_OFF_ACC_LO, 32'h0a);
        rd("irq_status", `ARA_OFF_IRQ_STAT, 32'h9);
        wr(`ARA_OFF_CNT, 32'hff);
        rd("count", `ARA_OFF_CNT, 32'h2);
        // Mode 010 accumulates like 001 here; the filter follows with no shift.
        ctl = 8'h20;
        wr(`ARA_OFF_CTRL2, {24'h0, ctl});
        sw(16'h0003);
        rd("acc_lo", `ARA_OFF_ACC_LO, 32'h0d);
        rd("count", `ARA_OFF_CNT, 32'h3);
        rd("filter", `ARA_OFF_FLT, 32'h0d);
        // The status read sees the state after the fourth edge: the clear must still be busy.
        wr(`ARA_OFF_CTRL2, {24'h0, ctl | 8'h08});
        cyc(3);
        rd("status", `ARA_OFF_STATUS, 32'h2);
        rd("status", `ARA_OFF_STATUS, 32'h0);
        rd("acc_lo", `ARA_OFF_ACC_LO, 32'h0);
        rd("count", `ARA_OFF_CNT, 32'h0);
        apb(1'b0, 12'h028, 32'h0);
        chk("slverr", {31'h0, e}, 32'h1);
        chk("unmapped", r, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
